// ==== core/zek_pkg.sv ====
package zek_pkg;
  localparam int ADDR_W = 11;
  localparam logic [10:0] SC_FIRST = 11'h050;
  localparam logic [10:0] SC_LAST = 11'h05f;
  localparam logic [10:0] CODE_ATTEMPT_COUNTER_FIRST = 11'h060;
  localparam logic [10:0] CODE_ATTEMPT_COUNTER_LAST = 11'h067;
  localparam logic [10:0] AZ1_FIRST = 11'h0b0;
  localparam logic [10:0] AZ1_LAST = 11'h2af;
  localparam logic [10:0] EZ1_FIRST = 11'h2b0;
  localparam logic [10:0] EZ1_LAST = 11'h2df;
  localparam logic [10:0] AZ2_FIRST = 11'h2e0;
  localparam logic [10:0] AZ2_LAST_EC = 11'h4d5;
  localparam logic [10:0] AZ2_LAST_NOEC = 11'h4df;
  localparam logic [10:0] EZ2_FIRST = 11'h4e0;
  localparam logic [10:0] EZ2_LAST = 11'h4ff;
  localparam logic [10:0] EC2_FIRST = 11'h500;
  localparam logic [10:0] EC2_LAST = 11'h57f;
  localparam logic [3:0] FAIL_LIMIT = 4'h8;
  localparam logic [7:0] EC2_LIMIT = 8'h80;
  // Register byte offsets
  localparam logic [7:0] REG_FUSE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  // Fuse register bits (1 = unblown)
  localparam int FB_ISSUER = 0;
  localparam int FB_MAKER = 1;
  localparam int FB_ECEN = 2;
  // Status register bits
  localparam int SB_E1 = 0;
  localparam int SB_E2 = 1;
  localparam int SB_VALID = 2;
  localparam int SB_LEVEL2 = 3;
  localparam int SB_LOCKED = 4;
  localparam int SB_MAKER_OK = 5;
  localparam int SB_EC_ARMED = 6;
  localparam logic RESET_FUSE = 1'b1;
endpackage

// ==== core/zek_zone_erase.sv ====
`timescale 1ns/1ns
module zek_zone_erase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic card_clk_i,
  input wire logic card_rst_i,
  input wire logic card_io_i,
  input wire logic level_force_pin_n_i,
  input wire logic mem_bit_i,
  input wire logic prog_req_i,
  input wire logic prog_erase_i,
  output logic az1_erase_o,
  output logic az2_erase_o,
  output logic [zek_pkg::ADDR_W-1:0] az2_erase_last_o,
  output logic [zek_pkg::ADDR_W-1:0] card_addr_o,
  output logic level2_o,
  output logic code_valid_flag_o,
  output logic card_locked_o,
  output logic maker_zone_wr_ok_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import zek_pkg::*;

  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] rst_sync;
    logic [1:0] io_sync;
    logic [1:0] force_sync;
    logic [10:0] addr;
    logic zone_one_erase_flag;
    logic zone_two_erase_flag;
    logic mis1;
    logic mis2;
    logic mis_sc;
    logic sc_seen;
    logic sc_armed;
    logic ec_armed;
    logic [10:0] armed_addr;
    logic code_valid_flag;
    logic [3:0] code_attempt_counter;
    logic locked;
    logic [7:0] ec_used;
    logic issuer_fuse;
    logic maker_fuse;
    logic erase_count_enable_fuse;
    logic az1_erase;
    logic az2_erase;
    logic [10:0] az2_last;
    logic ack;
    logic [31:0] dat;
  } zek_state_s;

  zek_state_s s_r;
  zek_state_s s_nxt;
  logic card_edge;
  logic card_rst;
  logic io_bit;
  logic level2;
  logic maker_eff;
  logic maker_ok;
  logic wb_req;
  logic wb_mapped;

  // ------------------------------------------------------------
  // Decoded levels
  // ------------------------------------------------------------
  assign card_edge = s_r.clk_sync[1] & ~s_r.clk_sync[2];
  assign card_rst = s_r.rst_sync[1];
  assign io_bit = s_r.io_sync[1];
  assign level2 = ~s_r.issuer_fuse | ~s_r.force_sync[1];
  assign maker_eff = s_r.maker_fuse & s_r.issuer_fuse;
  assign maker_ok = s_r.code_valid_flag & maker_eff;
  assign wb_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign wb_mapped = (wb_adr_i[7:4] == 4'h0) & (wb_adr_i[1:0] == 2'b00);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_sync = {s_r.clk_sync[1:0], card_clk_i};
    s_nxt.rst_sync = {s_r.rst_sync[0], card_rst_i};
    s_nxt.io_sync = {s_r.io_sync[0], card_io_i};
    s_nxt.force_sync = {s_r.force_sync[0], level_force_pin_n_i};
    s_nxt.az1_erase = 1'b0;
    s_nxt.az2_erase = 1'b0;
    s_nxt.ack = wb_req;

    // Bit-serial compare and address advance
    if (card_rst) begin
      s_nxt.addr = '0;
    end else if (card_edge) begin
      s_nxt.addr = s_r.addr + 11'h001;
      if (s_r.addr == SC_FIRST) begin
        s_nxt.mis_sc = (io_bit != mem_bit_i);
        s_nxt.sc_seen = 1'b0;
      end else if (s_r.addr > SC_FIRST && s_r.addr <= SC_LAST) begin
        s_nxt.mis_sc = s_r.mis_sc | (io_bit != mem_bit_i);
      end
      if (s_r.addr == SC_LAST) begin
        s_nxt.sc_seen = 1'b1;
      end
      if (s_r.addr == EZ1_FIRST) begin
        s_nxt.mis1 = (io_bit != mem_bit_i);
      end else if (s_r.addr > EZ1_FIRST && s_r.addr <= EZ1_LAST) begin
        s_nxt.mis1 = s_r.mis1 | (io_bit != mem_bit_i);
      end
      if (s_r.addr == EZ1_LAST) begin
        s_nxt.zone_one_erase_flag = ~(s_r.mis1 | (io_bit != mem_bit_i));
      end
      if (s_r.addr == EZ2_FIRST) begin
        s_nxt.mis2 = (io_bit != mem_bit_i);
      end else if (s_r.addr > EZ2_FIRST && s_r.addr <= EZ2_LAST) begin
        s_nxt.mis2 = s_r.mis2 | (io_bit != mem_bit_i);
      end
      if (s_r.addr == EZ2_LAST) begin
        s_nxt.zone_two_erase_flag = ~(s_r.mis2 | (io_bit != mem_bit_i));
      end
    end
    if (s_nxt.addr == '0) begin
      s_nxt.zone_one_erase_flag = 1'b0;
      s_nxt.zone_two_erase_flag = 1'b0;
      s_nxt.ec_armed = 1'b0;
      s_nxt.sc_armed = 1'b0;
    end

    // Program operations on the current bit
    if (prog_req_i && !card_rst) begin
      if (!prog_erase_i) begin
        if (s_r.addr >= CODE_ATTEMPT_COUNTER_FIRST && s_r.addr <= CODE_ATTEMPT_COUNTER_LAST && mem_bit_i && s_r.sc_seen) begin
          s_nxt.sc_armed = 1'b1;
          s_nxt.armed_addr = s_r.addr;
        end
        if (s_r.addr >= EC2_FIRST && s_r.addr <= EC2_LAST && mem_bit_i && s_r.zone_two_erase_flag) begin
          s_nxt.ec_armed = 1'b1;
          s_nxt.armed_addr = s_r.addr;
        end
      end else begin
        if (s_r.sc_armed && s_r.addr == s_r.armed_addr) begin
          s_nxt.sc_armed = 1'b0;
          s_nxt.sc_seen = 1'b0;
          if (!s_r.mis_sc && !s_r.locked) begin
            s_nxt.code_valid_flag = 1'b1;
            s_nxt.code_attempt_counter = '0;
          end else if (!s_r.locked) begin
            s_nxt.code_attempt_counter = s_r.code_attempt_counter + 4'h1;
            s_nxt.locked = (s_r.code_attempt_counter + 4'h1) == FAIL_LIMIT;
          end
        end
        if (level2 && s_r.zone_one_erase_flag && s_r.addr == AZ2_FIRST) begin
          s_nxt.az1_erase = 1'b1;
        end
        if (level2 && s_r.erase_count_enable_fuse && s_r.ec_armed && s_r.addr == s_r.armed_addr
            && s_r.ec_used != EC2_LIMIT) begin
          s_nxt.az2_erase = 1'b1;
          s_nxt.az2_last = AZ2_LAST_EC;
          s_nxt.ec_used = s_r.ec_used + 8'h01;
          s_nxt.ec_armed = 1'b0;
        end
        if (level2 && !s_r.erase_count_enable_fuse && s_r.zone_two_erase_flag && s_r.addr == EC2_FIRST) begin
          s_nxt.az2_erase = 1'b1;
          s_nxt.az2_last = AZ2_LAST_NOEC;
        end
      end
    end

    // Register bus, writes land at the edge that sees ack high
    if (wb_cyc_i && wb_stb_i && s_r.ack && wb_we_i && wb_sel_i[0] && wb_mapped && wb_adr_i == REG_FUSE) begin
      s_nxt.issuer_fuse = s_r.issuer_fuse & wb_dat_i[FB_ISSUER];
      s_nxt.maker_fuse = s_r.maker_fuse & wb_dat_i[FB_MAKER];
      if (s_r.issuer_fuse) begin
        s_nxt.erase_count_enable_fuse = wb_dat_i[FB_ECEN];
      end
    end
    if (wb_req) begin
      s_nxt.dat = '0;
      if (!wb_we_i && wb_mapped) begin
        case (wb_adr_i)
          REG_FUSE: begin
            s_nxt.dat[FB_ISSUER] = s_r.issuer_fuse;
            s_nxt.dat[FB_MAKER] = maker_eff;
            s_nxt.dat[FB_ECEN] = s_r.erase_count_enable_fuse;
          end
          REG_STATUS: begin
            s_nxt.dat[SB_E1] = s_r.zone_one_erase_flag;
            s_nxt.dat[SB_E2] = s_r.zone_two_erase_flag;
            s_nxt.dat[SB_VALID] = s_r.code_valid_flag;
            s_nxt.dat[SB_LEVEL2] = level2;
            s_nxt.dat[SB_LOCKED] = s_r.locked;
            s_nxt.dat[SB_MAKER_OK] = maker_ok;
            s_nxt.dat[SB_EC_ARMED] = s_r.ec_armed;
          end
          REG_ADDR: s_nxt.dat[10:0] = s_r.addr;
          REG_COUNT: s_nxt.dat[15:0] = {s_r.ec_used, 4'h0, s_r.code_attempt_counter};
          default: s_nxt.dat = '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.rst_sync <= 2'b11;
      s_r.force_sync <= 2'b11;
      s_r.issuer_fuse <= RESET_FUSE;
      s_r.maker_fuse <= RESET_FUSE;
      s_r.erase_count_enable_fuse <= RESET_FUSE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign az1_erase_o = s_r.az1_erase;
  assign az2_erase_o = s_r.az2_erase;
  assign az2_erase_last_o = s_r.az2_last;
  assign card_addr_o = s_r.addr;
  assign level2_o = level2;
  assign code_valid_flag_o = s_r.code_valid_flag;
  assign card_locked_o = s_r.locked;
  assign maker_zone_wr_ok_o = maker_ok;
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_az1_cause;
    prog_req_i && prog_erase_i && !card_rst && level2 && s_r.zone_one_erase_flag && s_r.addr == AZ2_FIRST;
  endsequence

  property p_e1_zero;
    (s_r.addr == 11'h000) |-> !s_r.zone_one_erase_flag;
  endproperty
  a_e1_zero: assert property (p_e1_zero) else $error("zone one flag set at address zero");

  property p_e2_zero;
    (s_r.addr == 11'h000) |-> !s_r.zone_two_erase_flag;
  endproperty
  a_e2_zero: assert property (p_e2_zero) else $error("zone two flag set at address zero");

  property p_az1_erase;
    s_az1_cause |=> az1_erase_o;
  endproperty
  a_az1_erase: assert property (p_az1_erase) else $error("zone one erase missed");

  property p_e1_set;
    $rose(s_r.zone_one_erase_flag) |-> $past(s_r.addr) == EZ1_LAST && s_r.addr == AZ2_FIRST;
  endproperty
  a_e1_set: assert property (p_e1_set) else $error("zone one flag set off the key end");

  property p_e2_set;
    $rose(s_r.zone_two_erase_flag) |-> $past(s_r.addr) == EZ2_LAST;
  endproperty
  a_e2_set: assert property (p_e2_set) else $error("zone two flag set off the key end");

  property p_az2_noec;
    az2_erase_o && az2_erase_last_o == AZ2_LAST_NOEC |-> $past(s_r.addr) == EC2_FIRST && !s_r.erase_count_enable_fuse;
  endproperty
  a_az2_noec: assert property (p_az2_noec) else $error("zone two erase without cause");

  property p_ec_limit;
    s_r.ec_used <= EC2_LIMIT;
  endproperty
  a_ec_limit: assert property (p_ec_limit) else $error("zone two erase count over limit");

  property p_maker;
    maker_zone_wr_ok_o |-> code_valid_flag_o && s_r.issuer_fuse && s_r.maker_fuse;
  endproperty
  a_maker: assert property (p_maker) else $error("maker zone open without conditions");

  property p_ec_frozen;
    !s_r.issuer_fuse |=> $stable(s_r.erase_count_enable_fuse);
  endproperty
  a_ec_frozen: assert property (p_ec_frozen) else $error("counter fuse changed after issuer");

  property p_force;
    !s_r.force_sync[1] |-> level2_o;
  endproperty
  a_force: assert property (p_force) else $error("forcing pin ignored");

  property p_valid_sticky;
    code_valid_flag_o |=> code_valid_flag_o [*2];
  endproperty
  a_valid_sticky: assert property (p_valid_sticky) else $error("code valid flag dropped");

  property p_lock;
    s_r.code_attempt_counter == FAIL_LIMIT |-> card_locked_o;
  endproperty
  a_lock: assert property (p_lock) else $error("card not locked after failures");
endmodule

// ==== testbench/zek_host_model.sv ====
`timescale 1ns/1ns
module zek_host_model (
  input wire logic clk_i,
  input wire logic [zek_pkg::ADDR_W-1:0] addr_i,
  output logic card_clk_o,
  output logic card_rst_o,
  output logic card_io_o,
  output logic mem_bit_o
);
  import zek_pkg::*;
  // ------------------------------------------------------------
  // Card memory image, keys already personalised
  // ------------------------------------------------------------
  function automatic logic img(input logic [ADDR_W-1:0] a);
    return (^(a & 11'h015)) | (a == 11'h060) | (a == 11'h500);
  endfunction
  assign mem_bit_o = img(addr_i);
  initial begin
    card_clk_o = 1'b0;
    card_rst_o = 1'b0;
    card_io_o = 1'b1;
  end
  // ------------------------------------------------------------
  // Address reset, clock stays low meanwhile
  // ------------------------------------------------------------
  task automatic addr_reset();
    @(posedge clk_i);
    card_rst_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    card_rst_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // ------------------------------------------------------------
  // Clock bits until target, io held through each pulse
  // ------------------------------------------------------------
  task automatic run_to(input logic [ADDR_W-1:0] target, input logic [ADDR_W-1:0] flip);
    int n;
    n = 0;
    while (addr_i !== target && n < 2048) begin
      card_io_o <= img(addr_i) ^ (addr_i == flip);
      repeat (4) @(posedge clk_i);
      card_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      card_clk_o <= 1'b0;
      n++;
    end
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ==== testbench/zek_zone_erase_tb.sv ====
`timescale 1ns/1ns
module zek_zone_erase_tb;
  import zek_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic card_clk_i, card_rst_i, card_io_i, mem_bit_i;
  logic level_force_pin_n_i = 1'b1;
  logic prog_req_i = 1'b0;
  logic prog_erase_i = 1'b0;
  logic az1_erase_o, az2_erase_o, level2_o, code_valid_flag_o, card_locked_o, maker_zone_wr_ok_o;
  logic [ADDR_W-1:0] az2_erase_last_o, card_addr_o;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  int bad_count = 0;
  int check_count = 0;
  always #50 clk_i = ~clk_i;
  zek_zone_erase u_dut (.clk_i(clk_i), .rst_i(rst_i), .card_clk_i(card_clk_i), .card_rst_i(card_rst_i),
    .card_io_i(card_io_i), .level_force_pin_n_i(level_force_pin_n_i), .mem_bit_i(mem_bit_i),
    .prog_req_i(prog_req_i), .prog_erase_i(prog_erase_i), .az1_erase_o(az1_erase_o),
    .az2_erase_o(az2_erase_o), .az2_erase_last_o(az2_erase_last_o), .card_addr_o(card_addr_o),
    .level2_o(level2_o), .code_valid_flag_o(code_valid_flag_o), .card_locked_o(card_locked_o),
    .maker_zone_wr_ok_o(maker_zone_wr_ok_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  zek_host_model u_host (.clk_i(clk_i), .addr_i(card_addr_o), .card_clk_o(card_clk_i),
    .card_rst_o(card_rst_i), .card_io_o(card_io_i), .mem_bit_o(mem_bit_i));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) chk("wb_ack", 32'h1, 32'h0);
  endtask
  task automatic reg_chk(input string name, input logic [7:0] adr, input logic [31:0] mask,
                         input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0, rd);
    chk(name, exp, rd & mask);
  endtask
  task automatic reg_wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    wb(1'b1, adr, wd, rd);
  endtask
  task automatic prog(input logic erase, input logic [1:0] exp);
    logic [1:0] seen;
    seen = 2'b00;
    @(posedge clk_i);
    prog_req_i <= 1'b1;
    prog_erase_i <= erase;
    @(posedge clk_i);
    prog_req_i <= 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      seen = seen | {az2_erase_o, az1_erase_o};
    end
    chk("erase_pulses", {30'h0, exp}, {30'h0, seen});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_force();
    reg_chk("fuse", REG_FUSE, 32'hffffffff, 32'h7);
    reg_chk("status", REG_STATUS, 32'hffffffff, 32'h0);
    reg_chk("unmapped", 8'h10, 32'hffffffff, 32'h0);
    chk("level2_idle", 32'h0, {31'h0, level2_o});
    level_force_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("level2_forced", 32'h1, {31'h0, level2_o});
  endtask
  task automatic t_code();
    u_host.addr_reset();
    u_host.run_to(11'h060, 11'h7ff);
    chk("card_addr", 32'h60, {21'h0, card_addr_o});
    reg_chk("addr_reg", REG_ADDR, 32'h7ff, 32'h60);
    prog(1'b0, 2'b00);
    prog(1'b1, 2'b00);
    reg_chk("code_valid", REG_STATUS, 32'h4, 32'h4);
    chk("valid_pin", 32'h1, {31'h0, code_valid_flag_o});
    chk("maker_ok", 32'h1, {31'h0, maker_zone_wr_ok_o});
  endtask
  task automatic t_lock();
    repeat (8) begin
      u_host.addr_reset();
      u_host.run_to(11'h060, 11'h055);
      prog(1'b0, 2'b00);
      prog(1'b1, 2'b00);
    end
    chk("locked", 32'h1, {31'h0, card_locked_o});
    reg_chk("fail_count", REG_COUNT, 32'hf, 32'h8);
    chk("valid_kept", 32'h1, {31'h0, code_valid_flag_o});
  endtask
  task automatic t_zone_one(input logic [ADDR_W-1:0] flip, input logic ok);
    u_host.addr_reset();
    u_host.run_to(11'h2e0, flip);
    reg_chk("e1_set", REG_STATUS, 32'h1, {31'h0, ok});
    prog(1'b1, {1'b0, ok});
    u_host.addr_reset();
    reg_chk("e1_clear", REG_STATUS, 32'h1, 32'h0);
  endtask
  task automatic t_zone_two(input logic ec_on, input logic [ADDR_W-1:0] last);
    u_host.addr_reset();
    u_host.run_to(11'h500, 11'h7ff);
    reg_chk("e2_set", REG_STATUS, 32'h2, 32'h2);
    if (ec_on) prog(1'b0, 2'b00);
    prog(1'b1, 2'b10);
    chk("az2_last", {21'h0, last}, {21'h0, az2_erase_last_o});
    u_host.addr_reset();
    reg_chk("e2_clear", REG_STATUS, 32'h2, 32'h0);
  endtask
  task automatic t_fuses();
    level_force_pin_n_i <= 1'b1;
    reg_wr(REG_FUSE, 32'h3);
    reg_chk("ecen_blown", REG_FUSE, 32'h7, 32'h3);
    reg_wr(REG_FUSE, 32'h2);
    reg_chk("issuer_blown", REG_FUSE, 32'h7, 32'h0);
    reg_wr(REG_FUSE, 32'h7);
    reg_chk("ecen_frozen", REG_FUSE, 32'h7, 32'h0);
    chk("level2_issuer", 32'h1, {31'h0, level2_o});
    chk("maker_locked", 32'h0, {31'h0, maker_zone_wr_ok_o});
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_and_force();
    t_code();
    t_lock();
    t_zone_one(11'h7ff, 1'b1);
    t_zone_one(11'h7ff, 1'b1);
    t_zone_one(11'h2bc, 1'b0);
    t_zone_two(1'b1, 11'h4d5);
    reg_chk("ec2_used", REG_COUNT, 32'hff00, 32'h100);
    reg_wr(REG_FUSE, 32'h3);
    t_zone_two(1'b0, 11'h4df);
    t_fuses();
    report_and_stop();
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule
